// ---- white_balance_control_regs.sv ----
// White-balance control register bank with statistics gate and readback.
// Assumes register port, pixel stream and frame strobes share clock.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Pixels above the upper limit register, reset all ones, are excluded.
// - Pixels below the lower limit register, reset zero, are excluded.
// - Colour-temperature algorithm runs only while its enable is set.
// - Simple-algorithm feedback applies only while its enable is set.
// - Both enables: only an all-zero byte means disabled.
// - Work mode 00 separate, 01 long, 10 short, 11 combined; no mode until written.
// - Start-up registers have no reset value; read as zero until written.
// - Simple minimum count is 16 bits, high byte then low byte.
// - Colour-temperature minimum count is 16 bits in two byte registers.
// - Relative step in one register, absolute step in the next.
// - Long and short 10-bit gains read back, high two bits first.
// - Long and short 10-bit two's complement offsets read back.
// - Gamma luma and chroma thresholds are 10 bits in paired registers.
// - Eight fix bits force long and short sums and counts.
// - Fix control holds whole fix, end-of-frame fix and 4-bit value.
// - Debug mode 1 forces always; mode 2 end of frame to vsync.
// - The two debug control registers have no effect on the block.
// - Mode select 0 means automatic gains, 1 means manual gains.
module white_balance_control_regs
   import wb_regs_pkg::*;
(
   // Clock, reset, freeze
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   // Pixel statistics gate
   input wire logic pix_valid,
   input wire logic [DATA_W-1:0] pix_data,
   output logic stat_include,
   // Frame timing and results
   input wire logic frame_end,
   input wire logic vsync,
   input wire logic [VAL_W-1:0] gain_value [GAIN_COUNT],
   input wire logic [VAL_W-1:0] offset_value [GAIN_COUNT],
   // Algorithm controls
   output logic ct_enable,
   output logic feedback_enable,
   output logic [3:0] work_mode_onehot,
   output logic [15:0] simple_min_count,
   output logic [15:0] ct_min_count,
   output logic [DATA_W-1:0] relative_step,
   output logic [DATA_W-1:0] absolute_step,
   output logic manual_gain_select,
   output logic [DATA_W-1:0] ct_tuning [TUNE_COUNT],
   output logic [VAL_W-1:0] thresholds [THR_COUNT],
   // Statistic fixing and debug
   output logic [DATA_W-1:0] fix_select,
   output logic fix_whole,
   output logic fix_eof,
   output logic [3:0] fix_value,
   output logic debug_force,
   output logic [3:0] debug_value
);

   // ==========================================
   // Storage
   logic [DATA_W-1:0] rw_reg [RW_COUNT];
   logic [DATA_W-1:0] cfg_reg [CFG_COUNT];
   logic [CFG_COUNT-1:0] cfg_written;
   logic [VAL_W-1:0] snap [SNAP_COUNT];
   logic eof_window;

   wire logic [RW_COUNT-1:0] rw_hit;
   wire logic [CFG_COUNT-1:0] cfg_hit;
   wire logic wr_go = clk_en && reg_write;
   wire logic snap_hit = (reg_addr >= SNAP_BASE) && (reg_addr <= SNAP_LAST);
   wire logic [ADDR_W-1:0] snap_off = reg_addr - SNAP_BASE;
   wire logic [VAL_W-1:0] snap_sel = snap[snap_off[4:1]];

   // Masked cfg value: unwritten reads as zero
   function automatic logic [DATA_W-1:0] cfg_val(input int i);
      cfg_val = cfg_written[i] ? cfg_reg[i] : BYTE_ZERO;
   endfunction

   // Enable byte decode shared by both enables
   function automatic logic byte_enabled(input logic [DATA_W-1:0] b);
      byte_enabled = b != BYTE_ZERO;
   endfunction

   // ==========================================
   // Reset-valued registers
   genvar g;
   generate
      for (g = 0; g < RW_COUNT; g++)
      begin : gen_rw
         assign rw_hit[g] = (reg_addr == RW_ADDR[g]);
         always_ff @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               rw_reg[g] <= RW_RESET[g];
            else if (wr_go && rw_hit[g])
               rw_reg[g] <= reg_wdata & RW_MASK[g];
         end
      end
      // Start-up registers, no reset on the data
      for (g = 0; g < CFG_COUNT; g++)
      begin : gen_cfg
         assign cfg_hit[g] = (reg_addr == CFG_ADDR[g]);
         always_ff @(posedge clock)
         begin
            if (wr_go && cfg_hit[g])
               cfg_reg[g] <= reg_wdata;
         end
      end
      // Readback snapshot taken at frame end
      for (g = 0; g < SNAP_COUNT; g++)
      begin : gen_snap
         always_ff @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               snap[g] <= '0;
            else if (clk_en && frame_end)
               snap[g] <= (g < GAIN_COUNT) ? gain_value[g % GAIN_COUNT]
                                           : offset_value[g % GAIN_COUNT];
         end
      end
      for (g = 0; g < TUNE_COUNT; g++)
      begin : gen_tune
         assign ct_tuning[g] = rw_reg[g];
      end
      for (g = 0; g < THR_COUNT; g++)
      begin : gen_thr
         assign thresholds[g] = {rw_reg[IDX_THR + 2 * g][HI_W-1:0],
                                 rw_reg[IDX_THR + 2 * g + 1]};
      end
   endgenerate

   assign fix_select = rw_reg[IDX_FIX_SEL];
   assign fix_whole = rw_reg[IDX_FIX_CTL][FIX_WHOLE_BIT];
   assign fix_eof = rw_reg[IDX_FIX_CTL][FIX_EOF_BIT];
   assign fix_value = rw_reg[IDX_FIX_CTL][FIX_VALUE_MSB:0];
   assign manual_gain_select = rw_reg[IDX_MANUAL][0];

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         cfg_written <= '0;
      else if (wr_go)
         cfg_written <= cfg_written | cfg_hit;
   end

   // ==========================================
   // Read path
   logic [DATA_W-1:0] next_rdata;
   always_comb
   begin
      next_rdata = BYTE_ZERO;
      if (snap_hit)
         next_rdata = snap_off[0] ? snap_sel[DATA_W-1:0]
                                  : {6'h00, snap_sel[VAL_W-1:DATA_W]};
      for (int i = 0; i < RW_COUNT; i++)
         if (rw_hit[i])
            next_rdata = rw_reg[i];
      for (int i = 0; i < CFG_COUNT; i++)
         if (cfg_hit[i])
            next_rdata = cfg_val(i);
   end

   // ==========================================
   // Decoded controls
   wire logic [DATA_W-1:0] mode_byte = cfg_val(CFG_MODE);
   wire logic [1:0] mode_field = mode_byte[1:0];
   wire logic [DATA_W-1:0] upper_limit = rw_reg[IDX_UPPER];
   wire logic [DATA_W-1:0] lower_limit = rw_reg[IDX_LOWER];
   wire logic [DATA_W-1:0] dbg_mode = rw_reg[IDX_DBG_MODE];
   wire logic [3:0] dbg_raw = dbg_mode[DBG_VALUE_MSB:DBG_VALUE_LSB];
   wire logic next_stat_include = pix_valid && (pix_data <= upper_limit)
                                  && (pix_data >= lower_limit);
   wire logic next_ct_enable = byte_enabled(cfg_val(CFG_CT_EN));
   wire logic next_feedback_enable = byte_enabled(cfg_val(CFG_FEEDBACK));
   wire logic [3:0] mode_decode = {mode_field == MODE_COMBINE, mode_field == MODE_SHORT,
                                   mode_field == MODE_LONG,
                                   mode_field == MODE_SEPARATE};
   // Unwritten mode selects no mode at all
   wire logic [3:0] next_work_mode = cfg_written[CFG_MODE] ? mode_decode : '0;
   wire logic next_eof_window = frame_end || (eof_window && !vsync);
   wire logic next_debug_force = dbg_mode[DBG_MODE1_BIT]
                                 || (dbg_mode[DBG_MODE2_BIT] && eof_window);
   wire logic [3:0] next_debug_value = (dbg_raw == 4'h0) ? DBG_VALUE_MIN : dbg_raw;

   // ==========================================
   // Register read answer
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         reg_rdata <= '0;
         reg_rvalid <= 1'b0;
      end
      else if (clk_en)
      begin
         reg_rdata <= reg_read ? next_rdata : reg_rdata;
         reg_rvalid <= reg_read;
      end
   end

   // Pixel gate
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         stat_include <= 1'b0;
      else if (clk_en)
         stat_include <= next_stat_include;
   end

   // Algorithm enables and work mode
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         ct_enable <= 1'b0;
         feedback_enable <= 1'b0;
         work_mode_onehot <= '0;
      end
      else if (clk_en)
      begin
         ct_enable <= next_ct_enable;
         feedback_enable <= next_feedback_enable;
         work_mode_onehot <= next_work_mode;
      end
   end

   // Minimum counts and steps
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         simple_min_count <= '0;
         ct_min_count <= '0;
         relative_step <= '0;
         absolute_step <= '0;
      end
      else if (clk_en)
      begin
         simple_min_count <= {cfg_val(CFG_SIMPLE_HI), cfg_val(CFG_SIMPLE_LO)};
         ct_min_count <= {cfg_val(CFG_CT_HI), cfg_val(CFG_CT_LO)};
         relative_step <= cfg_val(CFG_STEP_REL);
         absolute_step <= cfg_val(CFG_STEP_ABS);
      end
   end

   // End-of-frame window and debug forcing
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         eof_window <= 1'b0;
         debug_force <= 1'b0;
         debug_value <= '0;
      end
      else if (clk_en)
      begin
         eof_window <= next_eof_window;
         debug_force <= next_debug_force;
         debug_value <= next_debug_value;
      end
   end

   // ==========================================
   // Checks
   AST_UPPER: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && pix_valid && pix_data > upper_limit |=> !stat_include)
      else $error("pixel above upper limit included");
   AST_LOWER: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && pix_valid && pix_data < lower_limit |=> !stat_include)
      else $error("pixel below lower limit included");
   AST_CT_EN: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && cfg_written[CFG_CT_EN] |=> ct_enable == ($past(cfg_reg[CFG_CT_EN]) != 8'h00))
      else $error("ct enable does not follow register");
   AST_FEEDBACK: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && cfg_written[CFG_FEEDBACK]
      |=> feedback_enable == ($past(cfg_reg[CFG_FEEDBACK]) != 8'h00))
      else $error("feedback enable does not follow register");
   AST_MODE: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && cfg_written[CFG_MODE] |=> $onehot(work_mode_onehot))
      else $error("work mode decode not one-hot");
   AST_MODE_IDLE: assert property (@(posedge clock) disable iff (!resetn)
      !cfg_written[CFG_MODE] |-> work_mode_onehot == '0)
      else $error("work mode active before written");
   AST_UNWRITTEN: assert property (@(posedge clock) disable iff (!resetn)
      !cfg_written[CFG_CT_EN] |-> !ct_enable)
      else $error("ct enable active before written");
   AST_MIN_COUNT: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && cfg_written[CFG_SIMPLE_HI] && cfg_written[CFG_SIMPLE_LO]
      |=> simple_min_count == {$past(cfg_reg[CFG_SIMPLE_HI]), $past(cfg_reg[CFG_SIMPLE_LO])})
      else $error("simple minimum count pairing wrong");
   AST_SNAP_LOAD: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && frame_end |=> snap[0] == $past(gain_value[0]))
      else $error("gain readback not captured at frame end");
   AST_SNAP_HOLD: assert property (@(posedge clock) disable iff (!resetn)
      !(clk_en && frame_end) |=> $stable(snap[SNAP_COUNT-1]))
      else $error("readback changed inside a frame");
   AST_DEBUG1: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && dbg_mode[DBG_MODE1_BIT] |=> debug_force && debug_value != 4'h0)
      else $error("debug mode 1 not forcing");
   AST_READ: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && reg_read && reg_addr == SNAP_BASE |=> reg_rvalid && reg_rdata[7:2] == 6'h00)
      else $error("gain high byte read wrong");

   // Start-up registers
   AST_FEED_IDLE: assert property (@(posedge clock) disable iff (!resetn)
      !cfg_written[CFG_FEEDBACK] |-> !feedback_enable)
      else $error("feedback active before written");

   AST_CT_COUNT: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && cfg_written[CFG_CT_HI] && cfg_written[CFG_CT_LO]
      |=> ct_min_count == {$past(cfg_reg[CFG_CT_HI]), $past(cfg_reg[CFG_CT_LO])})
      else $error("ct minimum count pairing wrong");

   AST_STEP: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && cfg_written[CFG_STEP_ABS]
      |=> absolute_step == $past(cfg_reg[CFG_STEP_ABS]))
      else $error("absolute step does not follow register");

   // Pixel gate
   AST_INCLUDE: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && pix_valid && pix_data <= upper_limit && pix_data >= lower_limit
      |=> stat_include)
      else $error("pixel inside limits excluded");

   AST_INVALID: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && !pix_valid |=> !stat_include)
      else $error("invalid pixel included");

   // Frame window
   AST_EOF_OPEN: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && frame_end |=> eof_window)
      else $error("frame end did not open window");

   AST_EOF_CLOSE: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && vsync && !frame_end |=> !eof_window)
      else $error("vsync did not close window");

   AST_DEBUG2: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && dbg_mode[DBG_MODE2_BIT] && eof_window |=> debug_force && debug_value != 4'h0)
      else $error("debug mode 2 not forcing");

   // Read port and freeze
   AST_RVALID: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && !reg_read |=> !reg_rvalid)
      else $error("read valid longer than one cycle");

   AST_READ_LO: assert property (@(posedge clock) disable iff (!resetn)
      clk_en && reg_read && reg_addr == SNAP_LAST
      |=> reg_rdata == $past(snap[SNAP_COUNT-1][DATA_W-1:0]))
      else $error("offset low byte read wrong");

   AST_FREEZE: assert property (@(posedge clock) disable iff (!resetn)
      !clk_en |=> $stable(snap[0]) && $stable(reg_rdata))
      else $error("state changed while frozen");

endmodule

`default_nettype wire

// ---- wb_regs_pkg.sv ----
// Constants for the white-balance control register bank.
// Assumes 8-bit register data and 16-bit register addresses.
package wb_regs_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int VAL_W = 10;
   localparam int HI_W = 2;
   localparam int RW_COUNT = 39;
   localparam int CFG_COUNT = 9;
   localparam int SNAP_COUNT = 16;
   localparam int GAIN_COUNT = 8;
   localparam int TUNE_COUNT = 7;
   localparam int THR_COUNT = 12;

   // ==========================================
   // Index of each reset-valued register used by name
   localparam int IDX_DEBUG_ONE = 7;
   localparam int IDX_DEBUG_TWO = 8;
   localparam int IDX_UPPER = 9;
   localparam int IDX_LOWER = 10;
   localparam int IDX_FIX_SEL = 11;
   localparam int IDX_FIX_CTL = 12;
   localparam int IDX_THR = 13;
   localparam int IDX_DBG_MODE = 37;
   localparam int IDX_MANUAL = 38;

   // Tuning: y tolerance, mid x, mid y, low k, high k, high x limit,
   // low y limit; then debug one/two, pixel limits, fix select/control,
   // twelve hi/lo threshold pairs, debug mode, manual gain select.
   localparam logic [ADDR_W-1:0] RW_ADDR [RW_COUNT] = '{
      16'h55a1, 16'h55a2, 16'h55a3, 16'h55a4, 16'h55a5, 16'h55a6, 16'h55a7,
      16'h55a8, 16'h55a9, 16'h55aa, 16'h55ab, 16'h55af, 16'h55b0,
      16'h5700, 16'h5701, 16'h5702, 16'h5703, 16'h5704, 16'h5705,
      16'h5706, 16'h5707, 16'h5708, 16'h5709, 16'h570a, 16'h570b,
      16'h570c, 16'h570d, 16'h570e, 16'h570f, 16'h5710, 16'h5711,
      16'h5712, 16'h5713, 16'h5714, 16'h5715, 16'h5716, 16'h5717,
      16'h5718, 16'h5120};
   localparam logic [DATA_W-1:0] RW_RESET [RW_COUNT] = '{
      8'h10, 8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h20, 8'h20, 8'hff, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h10, 8'h01, 8'h00, 8'h03, 8'h68,
      8'h00, 8'h80, 8'h00, 8'h20, 8'h00, 8'h10,
      8'h00, 8'h40, 8'h00, 8'h40, 8'h00, 8'h40,
      8'h00, 8'h80, 8'h00, 8'h10, 8'h00, 8'h10,
      8'h3c, 8'h00};
   localparam logic [DATA_W-1:0] RW_MASK [RW_COUNT] = '{
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f,
      8'h03, 8'hff, 8'h03, 8'hff, 8'h03, 8'hff,
      8'h03, 8'hff, 8'h03, 8'hff, 8'h03, 8'hff,
      8'h03, 8'hff, 8'h03, 8'hff, 8'h03, 8'hff,
      8'h03, 8'hff, 8'h03, 8'hff, 8'h03, 8'hff,
      8'h3f, 8'h01};

   // ==========================================
   // Start-up registers without reset value
   localparam int CFG_CT_EN = 0;
   localparam int CFG_MODE = 1;
   localparam int CFG_FEEDBACK = 2;
   localparam int CFG_SIMPLE_HI = 3;
   localparam int CFG_SIMPLE_LO = 4;
   localparam int CFG_CT_HI = 5;
   localparam int CFG_CT_LO = 6;
   localparam int CFG_STEP_REL = 7;
   localparam int CFG_STEP_ABS = 8;
   localparam logic [ADDR_W-1:0] CFG_ADDR [CFG_COUNT] = '{
      16'hc4b8, 16'hc4b9, 16'hc4ba, 16'hc4cc, 16'hc4cd,
      16'hc4ce, 16'hc4cf, 16'hc4d0, 16'hc4d1};

   // Gain and offset readback window
   localparam logic [ADDR_W-1:0] SNAP_BASE = 16'h5cfc;
   localparam logic [ADDR_W-1:0] SNAP_LAST = 16'h5d1b;

   // ==========================================
   // Fields
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [1:0] MODE_SEPARATE = 2'h0;
   localparam logic [1:0] MODE_LONG = 2'h1;
   localparam logic [1:0] MODE_SHORT = 2'h2;
   localparam logic [1:0] MODE_COMBINE = 2'h3;
   localparam int FIX_WHOLE_BIT = 5;
   localparam int FIX_EOF_BIT = 4;
   localparam int FIX_VALUE_MSB = 3;
   localparam int DBG_MODE1_BIT = 0;
   localparam int DBG_MODE2_BIT = 1;
   localparam int DBG_VALUE_MSB = 5;
   localparam int DBG_VALUE_LSB = 2;
   localparam logic [3:0] DBG_VALUE_MIN = 4'h1;

endpackage

// ---- white_balance_control_regs_tb.sv ----
// Self-checking bench for the white-balance control register bank.
// Assumes the bank alone on one 25 MHz clock, driven at its ports.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
   begin \
      checked = checked + 1; \
      if ((got) !== (exp)) \
      begin \
         fail_count = fail_count + 1; \
         $display("BAD %s expected %h seen %h", nm, exp, got); \
      end \
   end
module white_balance_control_regs_tb
   import wb_regs_pkg::*;
();
   logic clock, resetn, clk_en, reg_write, reg_read, reg_rvalid;
   logic pix_valid, stat_include, frame_end, vsync, ct_enable, feedback_enable;
   logic manual_gain_select, fix_whole, fix_eof, debug_force;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, pix_data, relative_step, absolute_step, fix_select;
   logic [3:0] work_mode_onehot, fix_value, debug_value;
   logic [15:0] simple_min_count, ct_min_count;
   logic [VAL_W-1:0] gain_value [GAIN_COUNT];
   logic [VAL_W-1:0] offset_value [GAIN_COUNT];
   logic [VAL_W-1:0] thresholds [THR_COUNT];
   logic [DATA_W-1:0] ct_tuning [TUNE_COUNT];
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;

   white_balance_control_regs uut (.clock(clock), .resetn(resetn), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .pix_valid(pix_valid), .pix_data(pix_data), .stat_include(stat_include),
      .frame_end(frame_end), .vsync(vsync), .gain_value(gain_value),
      .offset_value(offset_value), .ct_enable(ct_enable), .feedback_enable(feedback_enable),
      .work_mode_onehot(work_mode_onehot), .simple_min_count(simple_min_count),
      .ct_min_count(ct_min_count), .relative_step(relative_step),
      .absolute_step(absolute_step), .manual_gain_select(manual_gain_select),
      .ct_tuning(ct_tuning), .thresholds(thresholds), .fix_select(fix_select),
      .fix_whole(fix_whole), .fix_eof(fix_eof), .fix_value(fix_value),
      .debug_force(debug_force), .debug_value(debug_value));

   // ==========================================
   // Clock and hang guard
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles = cycles + 1;
      if (cycles == 5000)
      begin
         fail_count = fail_count + 1;
         print_verdict();
      end
   end

   // ==========================================
   // Bus helpers, entered just after a rising edge
   task automatic tick();
      @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      tick();
      reg_write = 1'b0;
      tick();
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
      reg_addr = a;
      reg_read = 1'b1;
      tick();
      reg_read = 1'b0;
      `CHK("rvalid", 1'b1, reg_rvalid)
      `CHK(nm, e, reg_rdata)
      tick();
      `CHK("rvalid low", 1'b0, reg_rvalid)
   endtask
   task automatic px(input logic v, input logic [DATA_W-1:0] d, input logic e);
      pix_valid = v;
      pix_data = d;
      tick();
      `CHK("stat_include", e, stat_include)
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset();
      for (int i = 0; i < RW_COUNT; i++)
         rd_chk(RW_ADDR[i], RW_RESET[i], "reset value");
      for (int i = 0; i < CFG_COUNT; i++)
         rd_chk(CFG_ADDR[i], 8'h00, "unwritten");
      `CHK("ct_enable", 1'b0, ct_enable)
      `CHK("work mode", 4'h0, work_mode_onehot)
      `CHK("tuning", 8'h10, ct_tuning[0])
      `CHK("thr", 10'h010, thresholds[0])
      `CHK("dbg value", 4'hf, debug_value)
      `CHK("dbg force", 1'b0, debug_force)
   endtask
   task automatic t_enables();
      logic [DATA_W-1:0] v [5] = '{8'h00, 8'h01, 8'h02, 8'h80, 8'hff};
      for (int i = 0; i < 5; i++)
      begin
         wr(CFG_ADDR[CFG_CT_EN], v[i]);
         `CHK("ct_enable", v[i] != 8'h00, ct_enable)
         wr(CFG_ADDR[CFG_FEEDBACK], ~v[i]);
         `CHK("feedback", ~v[i] != 8'h00, feedback_enable)
      end
   endtask
   task automatic t_mode();
      for (int m = 0; m < 4; m++)
      begin
         wr(CFG_ADDR[CFG_MODE], 8'hfc | m[7:0]);
         `CHK("work mode", 4'h1 << m, work_mode_onehot)
      end
   endtask
   task automatic t_counts();
      wr(CFG_ADDR[CFG_SIMPLE_HI], 8'hab);
      wr(CFG_ADDR[CFG_SIMPLE_LO], 8'hcd);
      wr(CFG_ADDR[CFG_CT_HI], 8'h12);
      wr(CFG_ADDR[CFG_CT_LO], 8'h34);
      wr(CFG_ADDR[CFG_STEP_REL], 8'h5a);
      wr(CFG_ADDR[CFG_STEP_ABS], 8'ha5);
      `CHK("simple count", 16'habcd, simple_min_count)
      `CHK("ct count", 16'h1234, ct_min_count)
      `CHK("rel step", 8'h5a, relative_step)
      `CHK("abs step", 8'ha5, absolute_step)
      rd_chk(CFG_ADDR[CFG_SIMPLE_LO], 8'hcd, "count lo");
   endtask
   task automatic t_pixels();
      wr(RW_ADDR[IDX_UPPER], 8'h90);
      wr(RW_ADDR[IDX_LOWER], 8'h20);
      px(1'b1, 8'h1f, 1'b0);
      px(1'b1, 8'h20, 1'b1);
      px(1'b1, 8'h90, 1'b1);
      px(1'b1, 8'h91, 1'b0);
      px(1'b0, 8'h50, 1'b0);
      px(1'b1, 8'h50, 1'b1);
      pix_valid = 1'b0;
   endtask
   task automatic t_thr_fix();
      wr(16'h5708, 8'hff);
      wr(16'h5709, 8'haa);
      wr(16'h5716, 8'h01);
      wr(16'h5717, 8'hfe);
      wr(16'h5702, 8'h02);
      `CHK("midtone l2", 10'h200, thresholds[1])
      `CHK("gamma y low", 10'h3aa, thresholds[4])
      `CHK("shadow uv2", 10'h1fe, thresholds[11])
      rd_chk(16'h5708, 8'h03, "masked hi");
      wr(RW_ADDR[IDX_FIX_SEL], 8'ha5);
      wr(RW_ADDR[IDX_FIX_CTL], 8'hda);
      `CHK("fix select", 8'ha5, fix_select)
      `CHK("fix bits", 6'h1a, {fix_whole, fix_eof, fix_value})
      rd_chk(RW_ADDR[IDX_FIX_CTL], 8'h1a, "fix ctl");
      wr(RW_ADDR[IDX_FIX_CTL], 8'h25);
      `CHK("fix bits", 6'h25, {fix_whole, fix_eof, fix_value})
   endtask
   task automatic t_debug();
      wr(RW_ADDR[IDX_DEBUG_ONE], 8'h00);
      wr(RW_ADDR[IDX_DEBUG_TWO], 8'hff);
      `CHK("dbg force", 1'b0, debug_force)
      wr(RW_ADDR[IDX_DBG_MODE], 8'h01);
      `CHK("dbg force", 1'b1, debug_force)
      wr(RW_ADDR[IDX_DBG_MODE], 8'h02);
      `CHK("dbg force", 1'b0, debug_force)
      `CHK("dbg value", 4'h1, debug_value)
      frame_end = 1'b1;
      tick();
      frame_end = 1'b0;
      `CHK("dbg force", 1'b0, debug_force)
      tick();
      `CHK("dbg force", 1'b1, debug_force)
      vsync = 1'b1;
      tick();
      vsync = 1'b0;
      `CHK("dbg force", 1'b1, debug_force)
      tick();
      `CHK("dbg force", 1'b0, debug_force)
   endtask
   task automatic t_readback();
      logic [VAL_W-1:0] e [SNAP_COUNT];
      for (int k = 0; k < GAIN_COUNT; k++)
      begin
         e[k] = 10'(10'h2a5 + 37 * k);
         e[k + 8] = 10'(10'h3f0 - 19 * k);
         gain_value[k] = e[k];
         offset_value[k] = e[k + 8];
      end
      frame_end = 1'b1;
      tick();
      frame_end = 1'b0;
      for (int k = 0; k < GAIN_COUNT; k++)
         gain_value[k] = ~e[k];
      for (int k = 0; k < SNAP_COUNT; k++)
      begin
         rd_chk(16'(SNAP_BASE + 2 * k), {6'h00, e[k][9:8]}, "snap hi");
         rd_chk(16'(SNAP_BASE + 2 * k + 1), e[k][7:0], "snap lo");
      end
      wr(SNAP_BASE, 8'hff);
      rd_chk(SNAP_BASE, {6'h00, e[0][9:8]}, "read only");
      wr(16'h55ac, 8'h77);
      rd_chk(16'h55ac, 8'h00, "unmapped");
      frame_end = 1'b1;
      tick();
      frame_end = 1'b0;
      e[0] = ~e[0];
      rd_chk(SNAP_BASE + 16'h0001, e[0][7:0], "next frame");
   endtask
   task automatic t_misc();
      wr(RW_ADDR[IDX_MANUAL], 8'hff);
      `CHK("manual", 1'b1, manual_gain_select)
      rd_chk(RW_ADDR[IDX_MANUAL], 8'h01, "manual reg");
      wr(RW_ADDR[IDX_MANUAL], 8'h00);
      `CHK("manual", 1'b0, manual_gain_select)
      wr(RW_ADDR[3], 8'h80);
      `CHK("low k", 8'h80, ct_tuning[3])
      clk_en = 1'b0;
      wr(RW_ADDR[0], 8'h99);
      clk_en = 1'b1;
      rd_chk(RW_ADDR[0], 8'h10, "frozen write");
      resetn = 1'b0;
      tick();
      tick();
      resetn = 1'b1;
      rd_chk(CFG_ADDR[CFG_STEP_REL], 8'h00, "after reset");
      `CHK("ct_enable", 1'b0, ct_enable)
      rd_chk(RW_ADDR[IDX_UPPER], 8'hff, "upper reset");
      `CHK("work mode", 4'h0, work_mode_onehot)
   endtask

   // ==========================================
   // Main sequence and verdict
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      resetn = 1'b0;
      clk_en = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      pix_valid = 1'b0;
      pix_data = '0;
      frame_end = 1'b0;
      vsync = 1'b0;
      gain_value = '{default: '0};
      offset_value = '{default: '0};
      repeat (12) @(posedge clock);
      #1;
      resetn = 1'b1;
      t_reset();
      t_enables();
      t_mode();
      t_counts();
      t_pixels();
      t_thr_fix();
      t_debug();
      t_readback();
      t_misc();
      print_verdict();
   end
endmodule
`default_nettype wire
